// ==== hdl/rire_exec.sv ====
// Purpose: executes return-from-interrupt and rotate-left-memory for the core
// Assumes: stack top and data memory read data behave as described at the ports
// Notes:   status flags are never written by either instruction
//
// Notes on behaviour
// - return from interrupt loads the program counter from the stack top and leaves the flags alone.
// - return from interrupt sets the master interrupt enable to one.
// - no interrupt is taken while the master interrupt enable is clear.
// - an interrupt pending at return from interrupt is entered before the main program resumes.
// - rotate left moves each memory bit up one place, bit 7 into bit 0, writes back, flags untouched.
`timescale 1ns/1ps
`default_nettype none

module rire_exec #(
	parameter int unsigned DATA_W = rire_pkg::DATA_W,
	parameter int unsigned PC_W   = rire_pkg::PC_W,
	parameter int unsigned ADDR_W = 8
) (
	input  wire logic              clk,
	input  wire logic              rst,
	// instruction issue from decode
	input  wire logic              op_valid,
	output logic                   op_ready,
	input  wire rire_pkg::rire_op_t op_code,
	input  wire logic [ADDR_W-1:0] op_addr,
	// hardware stack
	output logic                   stack_pop,
	input  wire logic [PC_W-1:0]   stack_top,
	// program counter load
	output logic                   pc_load,
	output logic      [PC_W-1:0]   pc_value,
	// data memory
	output logic                   mem_rd,
	output logic                   mem_wr,
	output logic      [ADDR_W-1:0] mem_addr,
	input  wire logic [DATA_W-1:0] mem_rdata,
	output logic      [DATA_W-1:0] mem_wdata,
	// status flag write strobe
	output logic                   flags_we,
	// master interrupt enable and interrupt entry
	input  wire logic              mie_wr,
	input  wire logic              mie_wr_val,
	output logic                   master_interrupt_enable,
	input  wire logic              irq_pending,
	output logic                   irq_take
);

	// widths the logic is built around
	if (DATA_W < 2) begin : g_bad_data
		$error("rire_exec: DATA_W must be at least 2");
	end
	if (PC_W != $bits(rire_pkg::PC_RST)) begin : g_bad_pc
		$error("rire_exec: PC_W must match the package reset value width");
	end

	rire_pkg::rire_state_t state_ff;
	rire_pkg::rire_state_t nxt_state;
	logic                  mie_ff;
	logic                  pc_load_ff;
	logic [PC_W-1:0]       pc_value_ff;
	logic [ADDR_W-1:0]     mem_addr_ff;
	logic [DATA_W-1:0]     mem_wdata_ff;
	logic [DATA_W-1:0]     rot_result;
	logic                  accept;
	logic                  acc_return_from_interrupt;
	logic                  acc_rotl;

	// pending interrupt outranks the next main-program instruction
	assign irq_take = (state_ff == rire_pkg::RIRE_ST_IDLE) && mie_ff && irq_pending;
	assign op_ready = (state_ff == rire_pkg::RIRE_ST_IDLE) && !irq_take;
	assign accept   = op_valid && op_ready;
	assign acc_return_from_interrupt = accept && (op_code == rire_pkg::RIRE_OP_RETURN_FROM_INTERRUPT);
	assign acc_rotl = accept && (op_code == rire_pkg::RIRE_OP_ROTATE_LEFT_MEMORY);

	// stack is read combinationally, so the pop is the accept cycle
	assign stack_pop = acc_return_from_interrupt;

	// neither instruction touches the flags
	assign flags_we = 1'h0;

	// memory strobes follow the sequencer
	assign mem_rd    = (state_ff == rire_pkg::RIRE_ST_ROT_READ);
	assign mem_wr    = (state_ff == rire_pkg::RIRE_ST_ROT_WRITE);
	assign mem_addr  = mem_addr_ff;
	assign mem_wdata = mem_wdata_ff;
	assign pc_load   = pc_load_ff;
	assign pc_value  = pc_value_ff;
	assign master_interrupt_enable = mie_ff;

	// byte rotator
	rire_rotl #(
		.WIDTH    (DATA_W)
	) u_rotl (
		.data_in  (mem_rdata),
		.data_out (rot_result)
	);

	// sequencer next state; return completes in the accept cycle
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			rire_pkg::RIRE_ST_IDLE: begin
				if (acc_rotl) begin
					nxt_state = rire_pkg::RIRE_ST_ROT_READ;
				end
			end
			rire_pkg::RIRE_ST_ROT_READ: begin
				nxt_state = rire_pkg::RIRE_ST_ROT_CAPTURE;
			end
			rire_pkg::RIRE_ST_ROT_CAPTURE: begin
				nxt_state = rire_pkg::RIRE_ST_ROT_WRITE;
			end
			rire_pkg::RIRE_ST_ROT_WRITE: begin
				nxt_state = rire_pkg::RIRE_ST_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_ff <= rire_pkg::RIRE_ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// program counter restore from stack top
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pc_load_ff  <= 1'h0;
			pc_value_ff <= rire_pkg::PC_RST;
		end else begin
			pc_load_ff <= acc_return_from_interrupt;
			if (acc_return_from_interrupt) begin
				pc_value_ff <= stack_top;
			end
		end
	end

	// master enable: return sets it, interrupt entry clears it,
	// other instructions may write it; return wins over a same-cycle write, then entry, then the write
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mie_ff <= rire_pkg::MIE_RST;
		end else if (acc_return_from_interrupt) begin
			mie_ff <= 1'h1;
		end else if (irq_take) begin
			mie_ff <= 1'h0; // nested entry blocked until the next return or a master enable write
		end else if (mie_wr) begin
			mie_ff <= mie_wr_val;
		end
	end

	// rotate datapath: address held through read and write
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mem_addr_ff  <= '0;
			mem_wdata_ff <= '0;
		end else begin
			if (acc_rotl) begin
				mem_addr_ff <= op_addr;
			end
			// read data is valid the cycle after the read strobe
			if (state_ff == rire_pkg::RIRE_ST_ROT_CAPTURE) begin
				mem_wdata_ff <= rot_result;
			end
		end
	end

	// checks

	chk_pc_restore: assert property (@(posedge clk) disable iff (rst)
		acc_return_from_interrupt |=> pc_load && (pc_value == $past(stack_top)) && !flags_we)
		else $error("program counter not restored from stack top");

	chk_mie_set: assert property (@(posedge clk) disable iff (rst)
		acc_return_from_interrupt |=> master_interrupt_enable)
		else $error("master enable not set after return from interrupt");

	chk_mie_gate: assert property (@(posedge clk) disable iff (rst)
		!master_interrupt_enable |-> !irq_take)
		else $error("interrupt taken while master enable clear");

	chk_pending_first: assert property (@(posedge clk) disable iff (rst)
		(acc_return_from_interrupt && irq_pending) ##1 irq_pending |-> irq_take && !op_ready)
		else $error("pending interrupt not entered before main program");

	chk_rotate_write: assert property (@(posedge clk) disable iff (rst)
		mem_wr |-> (mem_wdata == {$past(mem_rdata[DATA_W-2:0]), $past(mem_rdata[DATA_W-1])})
			&& (mem_addr == $past(mem_addr, 2)) && !flags_we)
		else $error("rotate result wrong on write back");

	// gating and ordering around interrupt entry
	chk_take_clears: assert property (@(posedge clk) disable iff (rst)
		irq_take |=> !master_interrupt_enable)
		else $error("master enable still set after interrupt entry");

	chk_mie_hold: assert property (@(posedge clk) disable iff (rst)
		(!acc_return_from_interrupt && !irq_take && !mie_wr) |=> (master_interrupt_enable == $past(master_interrupt_enable)))
		else $error("master enable changed with no cause");

	chk_take_blocks: assert property (@(posedge clk) disable iff (rst)
		irq_take |-> !op_ready && !stack_pop)
		else $error("instruction accepted while interrupt entry pending");

	// rotate sequencing and program counter source
	chk_busy_refuse: assert property (@(posedge clk) disable iff (rst)
		(state_ff != rire_pkg::RIRE_ST_IDLE) |-> !op_ready && !irq_take && !stack_pop)
		else $error("issue or entry allowed while rotate busy");

	chk_rotate_seq: assert property (@(posedge clk) disable iff (rst)
		acc_rotl |=> mem_rd && (mem_addr == $past(op_addr)) ##2 mem_wr)
		else $error("rotate read or write strobe out of order");

	chk_rd_pulse: assert property (@(posedge clk) disable iff (rst)
		mem_rd |=> !mem_rd && !mem_wr)
		else $error("read strobe longer than one cycle");

	chk_pc_load_cause: assert property (@(posedge clk) disable iff (rst)
		pc_load |-> $past(acc_return_from_interrupt))
		else $error("program counter loaded without a return");

endmodule : rire_exec

`default_nettype wire

// ==== hdl/rire_pkg.sv ====
// Purpose: shared constants and types for the return/rotate execution block
// Assumes: 8-bit data memory, program counter width set by the core
// Notes:   no software-visible registers live here
package rire_pkg;

	// data memory byte width
	localparam int unsigned DATA_W    = 8;
	// program counter width, core dependent
	localparam int unsigned PC_W      = 13;

	// reset values
	localparam logic        MIE_RST   = 1'h0;
	localparam logic [12:0] PC_RST    = 13'h0000;

	// instructions this block executes
	typedef enum logic [1:0] {
		RIRE_OP_NONE,
		RIRE_OP_RETURN_FROM_INTERRUPT,
		RIRE_OP_ROTATE_LEFT_MEMORY
	} rire_op_t;

	// sequencer states
	typedef enum logic [1:0] {
		RIRE_ST_IDLE,
		RIRE_ST_ROT_READ,
		RIRE_ST_ROT_CAPTURE,
		RIRE_ST_ROT_WRITE
	} rire_state_t;

endpackage : rire_pkg

// ==== hdl/rire_rotl.sv ====
// Purpose: combinational one-place left rotate of a data byte
// Assumes: width of at least two bits
// Notes:   top bit wraps into bit zero
`timescale 1ns/1ps
`default_nettype none

module rire_rotl #(
	parameter int unsigned WIDTH = 8
) (
	input  wire logic [WIDTH-1:0] data_in,
	output logic      [WIDTH-1:0] data_out
);

	// a one-bit rotate is meaningless
	if (WIDTH < 2) begin : g_bad_width
		$error("rire_rotl: WIDTH must be at least 2");
	end

	// each bit moves one place toward the top
	for (genvar i = 0; i < WIDTH - 1; i++) begin : g_shift
		assign data_out[i+1] = data_in[i];
	end

	// msb wraps around
	assign data_out[0] = data_in[WIDTH-1];

endmodule : rire_rotl

`default_nettype wire

// ==== verification/rire_exec_bench.sv ====
// Purpose: self-checking bench for the return/rotate execution block
// Assumes: inputs change at the falling edge, one cycle memory read latency
// Notes:   stack and memory are played by the bench itself
`timescale 1ns/1ps
`default_nettype none
module rire_exec_bench;
	logic               clk, rst, op_valid, mie_wr, mie_wr_val, irq_pending;
	rire_pkg::rire_op_t op_code;
	logic [7:0]         op_addr, mem_rdata, mem_addr, mem_wdata;
	logic [12:0]        stack_top, pc_value;
	logic               op_ready, stack_pop, pc_load, mem_rd, mem_wr, flags_we, mie, irq_take;
	int                 n_errors, total_checks, cycles;
	rire_exec i_rire_exec (.clk(clk), .rst(rst), .op_valid(op_valid), .op_ready(op_ready), .op_code(op_code),
		.op_addr(op_addr), .stack_pop(stack_pop), .stack_top(stack_top), .pc_load(pc_load), .pc_value(pc_value),
		.mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_wdata(mem_wdata),
		.flags_we(flags_we), .mie_wr(mie_wr), .mie_wr_val(mie_wr_val), .master_interrupt_enable(mie),
		.irq_pending(irq_pending), .irq_take(irq_take));
	// 200 MHz core clock
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic complete_run();
		if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : complete_run
	// hang guard, far above the 35 or so cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			n_errors++;
			complete_run();
		end
	end
	// return with the stack top driven only in the accept cycle
	task automatic ret(input logic [12:0] top, input logic pend);
		@(negedge clk);
		op_valid = 1'h1; op_code = rire_pkg::RIRE_OP_RETURN_FROM_INTERRUPT; stack_top = top; irq_pending = pend;
		#1; // let the decode settle
		chk("stack_pop", stack_pop, 16'h1);
		@(negedge clk);
		op_valid = 1'h0; stack_top = ~top;
		chk("pc_load", pc_load, 16'h1);
		chk("pc_value", pc_value, top);
		chk("mie", mie, 16'h1);
		chk("flags_we", flags_we, 16'h0);
		chk("irq_take", irq_take, pend);
		chk("op_ready", op_ready, !pend);
		if (pend) begin
			@(negedge clk);
			irq_pending = 1'h0;
			chk("mie after take", mie, 16'h0);
		end
	endtask : ret
	// rotate one byte; read data exists only in the cycle after the read strobe
	task automatic rot(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		op_valid = 1'h1; op_code = rire_pkg::RIRE_OP_ROTATE_LEFT_MEMORY; op_addr = a;
		chk("op_ready", op_ready, 16'h1);
		@(negedge clk);
		op_valid = 1'h0; op_addr = ~a;
		chk("mem_rd", mem_rd, 16'h1);
		chk("mem_addr", mem_addr, a);
		@(negedge clk);
		mem_rdata = d;
		@(negedge clk);
		mem_rdata = ~d;
		chk("mem_wr", mem_wr, 16'h1);
		chk("mem_wdata", mem_wdata, {d[6:0], d[7]});
		chk("flags_we", flags_we, 16'h0);
		@(negedge clk);
		chk("op_ready after", op_ready, 16'h1);
	endtask : rot
	// gate test: a clear master enable blocks a pending request
	task automatic gate();
		@(negedge clk);
		mie_wr = 1'h1; mie_wr_val = 1'h0;
		@(negedge clk);
		irq_pending = 1'h1; mie_wr_val = 1'h1;
		#1;
		chk("irq_take gated", irq_take, 16'h0);
		chk("op_ready gated", op_ready, 16'h1);
		@(negedge clk);
		mie_wr = 1'h0;
		chk("irq_take open", irq_take, 16'h1);
		@(negedge clk);
		irq_pending = 1'h0;
		chk("mie cleared", mie, 16'h0);
	endtask : gate
	initial begin
		rst = 1'h1; op_valid = 1'h0; op_code = rire_pkg::RIRE_OP_NONE; op_addr = 8'h00; stack_top = 13'h0000;
		mem_rdata = 8'h00; mie_wr = 1'h0; mie_wr_val = 1'h0; irq_pending = 1'h1;
		n_errors = 0; total_checks = 0; cycles = 0;
		repeat (6) @(negedge clk);
		chk("mie reset", mie, 16'h0);
		chk("irq_take reset", irq_take, 16'h0);
		rst = 1'h0; irq_pending = 1'h0;
		ret(13'h1abc, 1'h0);
		ret(13'h0543, 1'h0);
		gate();
		ret(13'h1fff, 1'h1);
		rot(8'h3c, 8'h80);
		rot(8'hff, 8'h01);
		rot(8'h00, 8'ha5);
		ret(13'h0000, 1'h1);
		complete_run();
	end
endmodule : rire_exec_bench
`default_nettype wire
